//--- src/lfalu_core.sv
// Execution datapath for literal, file and pointer arithmetic instructions
//
// Functional notes
// - Pointer add sign-extends six-bit literal, selects pointer
// - Pointer sum wraps modulo 65536
// - AND literal into accumulator, zero flag only
// - Add literal into accumulator, carry/digit/zero flags
// - AND accumulator with file, zero flag only
// - Destination bit picks accumulator or file
// - Add accumulator and file, route, three flags
// - Shift right; bit zero goes to carry
// - Shift keeps sign bit; result routed
// - Add with carry, routed, three flags
`timescale 1ns/100ps
`default_nettype none

module lfalu_core (
  input  wire logic                    clk_sys,
  input  wire logic                    sys_rst,
  input  wire logic                    instr_valid,
  input  wire lfalu_pkg::lfalu_instr_t instr,
  input  wire logic [7:0]              file_rdata,
  output var  logic [7:0]              acc,
  output var  lfalu_pkg::lfalu_flags_t flags,
  output var  logic [15:0]             indirect_pointer_0,
  output var  logic [15:0]             indirect_pointer_1,
  output var  lfalu_pkg::lfalu_fwr_t   file_wr
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Nine-bit sum; bit 8 is carry out of bit 7
  function automatic logic [8:0] lfalu_add8(input logic [7:0] a, input logic [7:0] b,
                                            input logic cin);
    lfalu_add8 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  endfunction : lfalu_add8

  // Carry out of bit 3, from the low nibbles alone
  function automatic logic lfalu_dc(input logic [7:0] a, input logic [7:0] b,
                                    input logic cin);
    logic [4:0] s;
    s = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    lfalu_dc = s[lfalu_pkg::DC_BIT];
  endfunction : lfalu_dc

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]              acc_q,   acc_d;    // Accumulator
  lfalu_pkg::lfalu_flags_t flags_q, flags_d;  // Status flags
  logic [15:0]             ptr0_q,  ptr0_d;   // Indirect pointer 0 (high:low bytes)
  logic [15:0]             ptr1_q,  ptr1_d;   // Indirect pointer 1
  lfalu_pkg::lfalu_fwr_t   fwr_q,   fwr_d;    // Registered file write-back

  // ----------------------------------------------------------------
  // Operand decode
  // ----------------------------------------------------------------
  wire lfalu_pkg::lfalu_op_t op = instr_valid ? instr.op : lfalu_pkg::LFALU_OP_NONE;

  // Literal ops use the immediate; file ops use the read data
  wire logic       use_lit  = (op == lfalu_pkg::LFALU_OP_AND_LITERAL_ACCUMULATOR) ||
                              (op == lfalu_pkg::LFALU_OP_ADD_LITERAL_ACCUMULATOR);
  wire logic [7:0] operand  = use_lit ? instr.literal : file_rdata;
  wire logic       cin      = (op == lfalu_pkg::LFALU_OP_ADD_ACCUMULATOR_FILE_CARRY)
                              ? flags_q.carry : 1'b0;

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  wire logic [8:0] sum      = lfalu_add8(acc_q, operand, cin);
  wire logic       dc_out   = lfalu_dc(acc_q, operand, cin);
  wire logic [7:0] and_res  = acc_q & operand;
  // Sign bit stays, bits 7..1 drop by one
  wire logic [7:0] asr_res  = {file_rdata[7], file_rdata[7:1]};

  // Sign extension of the six-bit pointer literal; 16-bit add drops overflow
  wire logic [15:0] plit_ext = {{10{instr.literal[5]}}, instr.literal[5:0]};
  wire logic [15:0] ptr_cur  = instr.ptr_sel ? ptr1_q : ptr0_q;
  wire logic [15:0] ptr_sum  = ptr_cur + plit_ext;

  // ----------------------------------------------------------------
  // Result selection
  // ----------------------------------------------------------------
  logic [7:0] result;
  logic       upd_c;     // Carry updated
  logic       upd_dc;    // Digit carry updated
  logic       upd_z;     // Zero updated
  logic       c_val;     // New carry value
  logic       file_op;   // Operation obeys the destination bit

  always_comb begin
    result  = sum[7:0];
    upd_c   = 1'b0;
    upd_dc  = 1'b0;
    upd_z   = 1'b0;
    c_val   = sum[8];
    file_op = 1'b0;
    unique case (op)
      lfalu_pkg::LFALU_OP_NONE: begin
        result = acc_q;
      end
      lfalu_pkg::LFALU_OP_ADD_LITERAL_TO_POINTER: begin
        result = acc_q;  // No flag touched
      end
      lfalu_pkg::LFALU_OP_AND_LITERAL_ACCUMULATOR: begin
        result = and_res;
        upd_z  = 1'b1;
      end
      lfalu_pkg::LFALU_OP_ADD_LITERAL_ACCUMULATOR: begin
        upd_c  = 1'b1;
        upd_dc = 1'b1;
        upd_z  = 1'b1;
      end
      lfalu_pkg::LFALU_OP_AND_ACCUMULATOR_FILE: begin
        result  = and_res;
        upd_z   = 1'b1;
        file_op = 1'b1;
      end
      lfalu_pkg::LFALU_OP_ADD_ACCUMULATOR_FILE,
      lfalu_pkg::LFALU_OP_ADD_ACCUMULATOR_FILE_CARRY: begin
        upd_c   = 1'b1;
        upd_dc  = 1'b1;
        upd_z   = 1'b1;
        file_op = 1'b1;
      end
      lfalu_pkg::LFALU_OP_ARITH_SHIFT_RIGHT_FILE: begin
        result  = asr_res;
        c_val   = file_rdata[0];
        upd_c   = 1'b1;
        upd_z   = 1'b1;
        file_op = 1'b1;
      end
    endcase
  end

  // AND/add literal ops always land in the accumulator; pointer add writes neither; file ops follow dest
  wire logic to_file = file_op && (instr.dest == lfalu_pkg::DEST_FILE);
  wire logic to_acc  = (op != lfalu_pkg::LFALU_OP_NONE) &&
                       (op != lfalu_pkg::LFALU_OP_ADD_LITERAL_TO_POINTER) && !to_file;

  // ----------------------------------------------------------------
  // Next-state values
  // ----------------------------------------------------------------
  always_comb begin
    acc_d               = to_acc ? result : acc_q;
    flags_d.carry       = upd_c  ? c_val  : flags_q.carry;
    flags_d.digit_carry = upd_dc ? dc_out : flags_q.digit_carry;
    flags_d.zero        = upd_z  ? (result == 8'h00) : flags_q.zero;
    ptr0_d = ptr0_q;
    ptr1_d = ptr1_q;
    if (op == lfalu_pkg::LFALU_OP_ADD_LITERAL_TO_POINTER) begin
      if (instr.ptr_sel) begin
        ptr1_d = ptr_sum;
      end else begin
        ptr0_d = ptr_sum;
      end
    end
    fwr_d.we   = to_file;
    fwr_d.addr = instr.file_addr;
    fwr_d.data = result;
  end

  // ----------------------------------------------------------------
  // Registers; the write strobe is one cycle wide, so the file port
  // sees each result exactly once even under back-to-back issue
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      acc_q   <= lfalu_pkg::ACC_RST;
      flags_q <= '{lfalu_pkg::FLAG_RST, lfalu_pkg::FLAG_RST, lfalu_pkg::FLAG_RST};
      ptr0_q  <= lfalu_pkg::PTR_RST;
      ptr1_q  <= lfalu_pkg::PTR_RST;
      fwr_q   <= '0;
    end else begin
      acc_q   <= acc_d;
      flags_q <= flags_d;
      ptr0_q  <= ptr0_d;
      ptr1_q  <= ptr1_d;
      fwr_q   <= fwr_d;
    end
  end

  assign acc                = acc_q;
  assign flags              = flags_q;
  assign indirect_pointer_0 = ptr0_q;
  assign indirect_pointer_1 = ptr1_q;
  assign file_wr            = fwr_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ptr_wrap_add: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (op == lfalu_pkg::LFALU_OP_ADD_LITERAL_TO_POINTER && !instr.ptr_sel) |=>
      ptr0_q == 16'($past(ptr0_q) + {{10{$past(instr.literal[5])}}, $past(instr.literal[5:0])}))
    else $error("pointer 0 add wrong");

  a_ptr_flags_kept: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (op == lfalu_pkg::LFALU_OP_ADD_LITERAL_TO_POINTER) |=> $stable(flags_q) && $stable(acc_q))
    else $error("pointer add changed flags");

  a_andlit_result: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (op == lfalu_pkg::LFALU_OP_AND_LITERAL_ACCUMULATOR) |=>
      acc_q == ($past(acc_q) & $past(instr.literal)) && $stable(flags_q.carry)
      && flags_q.zero == (acc_q == 8'h00))
    else $error("and literal wrong");

  a_addlit_carry: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (op == lfalu_pkg::LFALU_OP_ADD_LITERAL_ACCUMULATOR) |=>
      {flags_q.carry, acc_q} == {1'b0, $past(acc_q)} + {1'b0, $past(instr.literal)})
    else $error("add literal wrong");

  a_andfile_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (op == lfalu_pkg::LFALU_OP_AND_ACCUMULATOR_FILE) |=>
      flags_q.zero == (($past(acc_q) & $past(file_rdata)) == 8'h00)
      && $stable(flags_q.digit_carry))
    else $error("and file zero wrong");

  a_dest_file: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (file_op && instr.dest == lfalu_pkg::DEST_FILE) |=>
      file_wr.we && $stable(acc_q) && file_wr.addr == $past(instr.file_addr))
    else $error("file destination not honoured");

  a_addf_digit: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (op == lfalu_pkg::LFALU_OP_ADD_ACCUMULATOR_FILE) |=>
      flags_q.digit_carry ==
        (({1'b0, $past(acc_q[3:0])} + {1'b0, $past(file_rdata[3:0])}) > 5'h0f))
    else $error("digit carry wrong");

  a_asr_shift: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (op == lfalu_pkg::LFALU_OP_ARITH_SHIFT_RIGHT_FILE && instr.dest == lfalu_pkg::DEST_ACC) |=>
      acc_q[7] == $past(file_rdata[7]) && acc_q[6:0] == $past(file_rdata[7:1])
      && flags_q.carry == $past(file_rdata[0]) && !file_wr.we)
    else $error("shift wrong");

  a_addc_carry: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (op == lfalu_pkg::LFALU_OP_ADD_ACCUMULATOR_FILE_CARRY
     && instr.dest == lfalu_pkg::DEST_FILE) |=>
      {flags_q.carry, file_wr.data} ==
        {1'b0, $past(acc_q)} + {1'b0, $past(file_rdata)} + {8'h00, $past(flags_q.carry)})
    else $error("add with carry wrong");

endmodule : lfalu_core

`default_nettype wire

//--- src/lfalu_pkg.sv
// Package for the literal and file ALU datapath: operation codes, widths, carriers
`default_nettype none

package lfalu_pkg;

  // ----------------------------------------------------------------
  // Widths and ranges
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W    = 8;      // Accumulator and file width
  localparam int unsigned PTR_W     = 16;     // Indirect pointer width
  localparam int unsigned PLIT_W    = 6;      // Signed pointer literal width
  localparam int unsigned FADDR_W   = 7;      // File address width
  localparam int unsigned DC_BIT    = 4;      // Nibble boundary for digit carry
  localparam int unsigned NUM_PTR   = 2;      // Pointers 0 and 1

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  ACC_RST   = 8'h00;
  localparam logic [15:0] PTR_RST   = 16'h0000;
  localparam logic        FLAG_RST  = 1'b0;

  // ----------------------------------------------------------------
  // Destination select encoding
  // ----------------------------------------------------------------
  localparam logic DEST_ACC  = 1'b0;          // Result to accumulator
  localparam logic DEST_FILE = 1'b1;          // Result back to file register

  // ----------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LFALU_OP_NONE                       = 3'b000,
    LFALU_OP_ADD_LITERAL_TO_POINTER     = 3'b001,
    LFALU_OP_AND_LITERAL_ACCUMULATOR    = 3'b010,
    LFALU_OP_ADD_LITERAL_ACCUMULATOR    = 3'b011,
    LFALU_OP_AND_ACCUMULATOR_FILE       = 3'b100,
    LFALU_OP_ADD_ACCUMULATOR_FILE       = 3'b101,
    LFALU_OP_ARITH_SHIFT_RIGHT_FILE     = 3'b110,
    LFALU_OP_ADD_ACCUMULATOR_FILE_CARRY = 3'b111
  } lfalu_op_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    lfalu_op_t   op;         // Operation to execute
    logic [7:0]  literal;    // Immediate; low six bits for pointer add
    logic        ptr_sel;    // Pointer index 0 or 1
    logic [6:0]  file_addr;  // File register address
    logic        dest;       // Destination select
  } lfalu_instr_t;

  typedef struct packed {
    logic        carry;          // Carry out of bit 7
    logic        digit_carry;    // Carry out of bit 3
    logic        zero;           // Result was zero
  } lfalu_flags_t;

  typedef struct packed {
    logic        we;         // One-cycle write strobe
    logic [6:0]  addr;       // File address written
    logic [7:0]  data;       // Data written
  } lfalu_fwr_t;

endpackage : lfalu_pkg

`default_nettype wire

//--- test/literal_and_file_alu_ops_test.sv
// Self-checking testbench for the literal and file ALU datapath
`timescale 1ns/100ps
`default_nettype none

module literal_and_file_alu_ops_test;

  // ----------------------------------------------------------------
  // Stimulus, observed outputs and bench state
  // ----------------------------------------------------------------
  logic                    clk_sys     = 1'b0;   // 4 ns core clock
  logic                    sys_rst     = 1'b1;   // Async reset, active high
  logic                    instr_valid = 1'b0;   // Instruction present
  lfalu_pkg::lfalu_instr_t instr       = '0;     // Decoded instruction
  logic [7:0]              file_rdata  = 8'h00;  // Addressed file contents
  logic [7:0]              acc;                  // Accumulator seen
  lfalu_pkg::lfalu_flags_t flags;                // Status seen
  logic [15:0]             indirect_pointer_0;   // Pointer 0 seen
  logic [15:0]             indirect_pointer_1;   // Pointer 1 seen
  lfalu_pkg::lfalu_fwr_t   file_wr;              // Write-back seen
  int                      mismatches  = 0;      // Failed comparisons
  int                      compares    = 0;      // All comparisons
  logic [7:0]              e_acc       = 8'h00;  // Expected accumulator
  lfalu_pkg::lfalu_flags_t e_flg       = '0;     // Expected flags
  logic [15:0]             e_ptr [2]   = '{16'h0000, 16'h0000};
  lfalu_pkg::lfalu_fwr_t   e_fwr       = '0;     // Expected write-back

  // Free-running clock; half period of 2 ns
  always #2 clk_sys = ~clk_sys;

  lfalu_core uut (
    .clk_sys            (clk_sys),
    .sys_rst            (sys_rst),
    .instr_valid        (instr_valid),
    .instr              (instr),
    .file_rdata         (file_rdata),
    .acc                (acc),
    .flags              (flags),
    .indirect_pointer_0 (indirect_pointer_0),
    .indirect_pointer_1 (indirect_pointer_1),
    .file_wr            (file_wr)
  );

  // ----------------------------------------------------------------
  // Compare tasks, one per kind of result
  // ----------------------------------------------------------------
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_flg(input lfalu_pkg::lfalu_flags_t got, input lfalu_pkg::lfalu_flags_t exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_flg

  task automatic cmp_fwr(input lfalu_pkg::lfalu_fwr_t got, input lfalu_pkg::lfalu_fwr_t exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_fwr

  // Whole visible state; address and data only matter during a write
  task automatic check(input logic wr);
    cmp_val({8'h00, acc}, {8'h00, e_acc});
    cmp_val(indirect_pointer_0, e_ptr[0]);
    cmp_val(indirect_pointer_1, e_ptr[1]);
    cmp_flg(flags, e_flg);
    if (wr) begin
      cmp_fwr(file_wr, e_fwr);
    end else begin
      cmp_val({15'h0000, file_wr.we}, 16'h0000);
    end
  endtask : check

  // ----------------------------------------------------------------
  // One instruction: drive, predict, wait one edge, judge
  // ----------------------------------------------------------------
  // Valid is set high on every call and left high, so back-to-back calls issue on consecutive edges
  task automatic run(input logic [2:0] op, input logic [7:0] lit, input logic sel,
                     input logic [6:0] adr, input logic dst, input logic [7:0] fd);
    logic [7:0] b;
    logic       ci;
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    logic       wr;
    instr       = '{lfalu_pkg::lfalu_op_t'(op), lit, sel, adr, dst};
    file_rdata  = fd;
    instr_valid = 1'b1;
    wr = 1'b0;
    b  = (op == 3'h3) ? lit : fd;
    ci = (op == 3'h7) ? e_flg.carry : 1'b0;
    s  = {1'b0, e_acc} + {1'b0, b} + {8'h00, ci};
    h  = {1'b0, e_acc[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    case (op)
      3'h1: e_ptr[sel] = e_ptr[sel] + {{10{lit[5]}}, lit[5:0]};
      3'h2: r = e_acc & lit;
      3'h4: r = e_acc & fd;
      3'h6: r = {fd[7], fd[7:1]};
      default: r = s[7:0];
    endcase
    if (op >= 3'h2) begin
      e_flg.zero = (r == 8'h00);
    end
    if (op == 3'h3 || op == 3'h5 || op == 3'h7) begin
      e_flg.carry       = s[8];
      e_flg.digit_carry = h[4];
    end
    if (op == 3'h6) begin
      e_flg.carry = fd[0];
    end
    if (op >= 3'h4 && dst) begin
      wr    = 1'b1;
      e_fwr = '{1'b1, adr, r};
    end else if (op >= 3'h2) begin
      e_acc = r;
    end
    @(posedge clk_sys);
    #1;
    check(wr);
  endtask : run

  // Idle edge: nothing changes and any write strobe has dropped
  task automatic idle;
    instr_valid = 1'b0;
    @(posedge clk_sys);
    #1;
    check(1'b0);
  endtask : idle

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Literal ops ignore dest; carries on wrap and on the nibble edge
  task automatic t_literal;
    run(3'h3, 8'hFF, 1'b0, 7'h00, 1'b1, 8'hA5);
    run(3'h3, 8'h01, 1'b0, 7'h00, 1'b1, 8'h00);
    run(3'h3, 8'h0F, 1'b0, 7'h00, 1'b0, 8'h00);
    run(3'h3, 8'h01, 1'b0, 7'h00, 1'b0, 8'h00);
    run(3'h2, 8'hF3, 1'b0, 7'h00, 1'b1, 8'h00);
    run(3'h2, 8'h0F, 1'b0, 7'h00, 1'b0, 8'h00);
    idle();
  endtask : t_literal

  // Both pointers, both literal extremes, wrap both ways, flags held
  task automatic t_pointer;
    run(3'h1, 8'hE0, 1'b0, 7'h00, 1'b0, 8'h00);
    run(3'h1, 8'h1F, 1'b0, 7'h00, 1'b0, 8'h00);
    run(3'h1, 8'hC1, 1'b0, 7'h00, 1'b0, 8'h00);
    run(3'h1, 8'h5F, 1'b1, 7'h00, 1'b0, 8'h00);
    run(3'h1, 8'h20, 1'b1, 7'h00, 1'b0, 8'h00);
    run(3'h0, 8'hFF, 1'b1, 7'h7F, 1'b1, 8'hFF);
    idle();
  endtask : t_pointer

  // File ops back to back to both destinations, boundary addresses
  task automatic t_file;
    run(3'h3, 8'h37, 1'b0, 7'h00, 1'b0, 8'h00);
    for (int d = 0; d < 2; d++) begin
      run(3'h4, 8'h00, 1'b0, 7'h00, d[0], 8'h3C);
      run(3'h5, 8'h00, 1'b0, 7'h7F, d[0], 8'hF0);
      run(3'h6, 8'h00, 1'b0, 7'h55, d[0], 8'h81);
      run(3'h6, 8'h00, 1'b0, 7'h2A, d[0], 8'h42);
      run(3'h7, 8'h00, 1'b0, 7'h7F, d[0], 8'hFF);
      run(3'h7, 8'h00, 1'b0, 7'h01, d[0], 8'h00);
      run(3'h4, 8'h00, 1'b0, 7'h10, d[0], 8'h00);
      idle();
    end
  endtask : t_file

  // ----------------------------------------------------------------
  // Verdict, main sequence and watchdog
  // ----------------------------------------------------------------
  task automatic end_of_test;
    if (mismatches == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (6) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    check(1'b0);
    t_literal();
    t_pointer();
    t_file();
    end_of_test();
  end

  // Tests need well under a hundred cycles; this only catches a hang
  initial begin
    repeat (2000) @(posedge clk_sys);
    mismatches++;
    end_of_test();
  end

endmodule : literal_and_file_alu_ops_test

`default_nettype wire
